// ===== bench/crc_unit_checker.sv
`timescale 1ns/100ps
module crc_unit_checker
    import crc_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic [7:0] SFR_ADDR,
    input wire logic       SFR_WR,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       RES_RD,
    input wire logic       RES_WR,
    input wire logic [7:0] RES_WDATA,
    input wire logic [7:0] RES_RDATA
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire ctl_wr = SFR_WR && SFR_ADDR == CTRL_ADDR;
    wire ctl_rd = SFR_RD && SFR_ADDR == CTRL_ADDR && !SFR_WR;
    wire res_rd = RES_RD && !RES_WR && !SFR_WR;
    wire din_rd = SFR_RD && SFR_ADDR == DIN_ADDR && !SFR_WR;
    // ==========================================
    // register and result port checks
    a_ctrl_readback: assert property (
        ctl_wr ##1 ctl_rd |=> (SFR_RDATA & 8'h17) ==
        ($past(SFR_WDATA, 2) & 8'h17)) else $error("control readback");
    a_ptr_step: assert property (
        ctl_wr ##1 res_rd ##1 ctl_rd |=>
        ((SFR_RDATA - $past(SFR_WDATA, 3)) & 8'h03) == 8'h01)
        else $error("pointer step");
    a_init_seed: assert property (
        ctl_wr && SFR_WDATA[INIT_BIT] ##1 res_rd |=>
        RES_RDATA == {8{$past(SFR_WDATA[VAL_BIT], 2)}})
        else $error("seed");
    a_ctrl_unused: assert property (
        ctl_rd |=> SFR_RDATA[7:5] == 3'b000 && !SFR_RDATA[INIT_BIT])
        else $error("control unused bits");
    a_din_readback: assert property (
        SFR_WR && SFR_ADDR == DIN_ADDR ##1 din_rd |=>
        SFR_RDATA == $past(SFR_WDATA, 2)) else $error("data-in readback");
    a_unmapped_zero: assert property (
        SFR_RD && SFR_ADDR != CTRL_ADDR && SFR_ADDR != DIN_ADDR |=>
        SFR_RDATA == 8'h00) else $error("unmapped read");
    a_sfr_hold: assert property (
        !SFR_RD |=> $stable(SFR_RDATA)) else $error("sfr data moved");
    a_res_hold: assert property (
        !RES_RD |=> $stable(RES_RDATA)) else $error("result byte moved");
    a_reset_zero: assert property (
        $rose(RSTN) |-> SFR_RDATA == 8'h00 && RES_RDATA == 8'h00)
        else $error("reset outputs");
endmodule
bind crc_unit crc_unit_checker crc_unit_checker_inst (.CLK, .RSTN,
    .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA, .SFR_RDATA, .RES_RD,
    .RES_WR, .RES_WDATA, .RES_RDATA);

// ===== bench/crc_unit_tb_top.sv
`timescale 1ns/100ps
module crc_unit_tb_top
    import crc_pkg::*;
;
    typedef struct {
        logic [7:0]  ctrl;
        int          n;
        logic [39:0] bytes;
        logic [31:0] exp;
    } row_s;
    logic       CLK, RSTN, SFR_WR, SFR_RD, RES_WR, RES_RD;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, RES_WDATA, RES_RDATA;
    logic [7:0] want;
    int         n_fail, checked;
    row_s       rows [7];
    crc_unit crc_unit_inst (.CLK, .RSTN, .SFR_ADDR, .SFR_WR, .SFR_RD,
        .SFR_WDATA, .SFR_RDATA, .RES_RD, .RES_WR, .RES_WDATA, .RES_RDATA);
    initial begin
        CLK = 0;
        forever #25 CLK = ~CLK;
    end
    // one access per cycle, back to back; read data is settled on return
    task automatic acc(input logic [3:0] s, input logic [7:0] a, d);
        {SFR_WR, SFR_RD, RES_WR, RES_RD} = s;
        SFR_ADDR = a;
        SFR_WDATA = d;
        RES_WDATA = d;
        @(posedge CLK);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, s);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================
    // main sequence
    initial begin
        {RSTN, n_fail, checked} = 0;
        acc(4'h0, 8'h00, 8'h00);
        rows = '{'{8'h1c, 1, 40'h63, 32'hbd35}, '{8'h1c, 1, 40'h8c, 32'hb1f4},
            '{8'h1c, 1, 40'h7d, 32'h4eca}, '{8'h1c, 3, 40'haabbcc, 32'h6cf6},
            '{8'h1c, 5, 40'haabbcc, 32'hb166},
            '{8'h08, 1, 40'h80, 32'h690ce0ee},
            '{8'h0c, 1, 40'h00, 32'h4e08bfb4}};
        repeat (5) @(posedge CLK);
        #1 RSTN = 1;
        acc(4'h4, CTRL_ADDR, 8'h00);
        chk("ctrl reset", 8'h00, SFR_RDATA);
        acc(4'h4, DIN_ADDR, 8'h00);
        chk("din reset", 8'h00, SFR_RDATA);
        acc(4'h1, 8'h00, 8'h00);
        chk("result reset", 8'h00, RES_RDATA);
        foreach (rows[i]) begin
            acc(4'h8, CTRL_ADDR, rows[i].ctrl);
            for (int k = rows[i].n - 1; k >= 0; k--)
                acc(4'h8, DIN_ADDR, rows[i].bytes[8*k+:8]);
            for (int p = 0; p < 4; p++) begin
                acc(4'h1, 8'h00, 8'h00);
                want = rows[i].ctrl[4] ? rows[i].exp[8*(p%2)+:8]
                                       : rows[i].exp[8*p+:8];
                chk("res byte", want, RES_RDATA);
            end
        end
        acc(4'h8, CTRL_ADDR, 8'hff);
        acc(4'h1, 8'h00, 8'h00);
        chk("seed top lane", 8'hff, RES_RDATA);
        acc(4'h4, CTRL_ADDR, 8'h00);
        chk("ctrl unused bits", 8'h14, SFR_RDATA);
        acc(4'h2, 8'h00, 8'h5a);
        acc(4'h8, CTRL_ADDR, 8'h10);
        acc(4'h4, CTRL_ADDR, 8'h00);
        chk("ctrl write", 8'h10, SFR_RDATA);
        acc(4'h1, 8'h00, 8'h00);
        chk("result write", 8'h5a, RES_RDATA);
        acc(4'h4, CTRL_ADDR, 8'h00);
        chk("pointer step", 8'h11, SFR_RDATA);
        acc(4'h1, 8'h00, 8'h00);
        chk("result hold", 8'hff, RES_RDATA);
        acc(4'h8, 8'h94, 8'h5a);
        acc(4'h4, 8'h94, 8'h00);
        chk("unmapped", 8'h00, SFR_RDATA);
        acc(4'h8, DIN_ADDR, 8'h3c);
        acc(4'h4, DIN_ADDR, 8'h00);
        chk("din readback", 8'h3c, SFR_RDATA);
        acc(4'h0, 8'h00, 8'h00);
        // mid-run reset: outputs clear at once, state returns to reset values
        RSTN = 0;
        acc(4'h0, 8'h00, 8'h00);
        chk("mid reset sfr", 8'h00, SFR_RDATA);
        chk("mid reset result", 8'h00, RES_RDATA);
        RSTN = 1;
        acc(4'h4, CTRL_ADDR, 8'h00);
        chk("mid reset ctrl", 8'h00, SFR_RDATA);
        acc(4'h1, 8'h00, 8'h00);
        chk("mid reset value", 8'h00, RES_RDATA);
        acc(4'h0, 8'h00, 8'h00);
        finish_test;
    end
endmodule

// ===== core/crc_byte_fold.sv
`timescale 1ns/100ps
module crc_byte_fold
    import crc_pkg::*;
(
    crc_fold_if.engine fold
);
    // =====================================================
    // one byte folded per call, msb first
    function automatic logic [31:0] fold32(input logic [31:0] acc,
                                           input logic [7:0]  din);
        logic [31:0] r;
        r = acc ^ {din, 24'h000000};
        for (int i = 0; i < BITS_PER_BYTE; i++) begin
            if (r[31]) begin
                r = {r[30:0], 1'b0} ^ POLY32;
            end else begin
                r = {r[30:0], 1'b0};
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] fold16(input logic [15:0] acc,
                                           input logic [7:0]  din);
        logic [15:0] r;
        r = acc ^ {din, 8'h00};
        for (int i = 0; i < BITS_PER_BYTE; i++) begin
            if (r[15]) begin
                r = {r[14:0], 1'b0} ^ POLY16;
            end else begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction

    // upper half kept untouched in 16-bit mode
    assign fold.next = fold.narrow
                     ? {fold.acc[31:16], fold16(fold.acc[15:0], fold.din)}
                     : fold32(fold.acc, fold.din);
endmodule

// ===== core/crc_fold_if.sv
`timescale 1ns/100ps
interface crc_fold_if;
    logic [31:0] acc;
    logic [7:0]  din;
    logic        narrow;
    logic [31:0] next;

    modport engine (
        input  acc,
        input  din,
        input  narrow,
        output next
    );
    modport user (
        output acc,
        output din,
        output narrow,
        input  next
    );
endinterface

// ===== core/crc_pkg.sv
package crc_pkg;
    // =====================================================
    // register addresses
    localparam logic [7:0]  CTRL_ADDR       = 8'h92;
    localparam logic [7:0]  DIN_ADDR        = 8'h93;

    // =====================================================
    // control register fields
    localparam int          SEL_BIT         = 4;
    localparam int          INIT_BIT        = 3;
    localparam int          VAL_BIT         = 2;
    localparam int          PNT_LSB         = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [7:0]  DIN_RESET       = 8'h00;

    // =====================================================
    // polynomials and seeds
    localparam logic [31:0] POLY32          = 32'h04c11db7;
    localparam logic [15:0] POLY16          = 16'h1021;
    localparam logic [31:0] SEED_ZERO       = 32'h00000000;
    localparam logic [31:0] SEED_ONES       = 32'hffffffff;
    localparam logic [31:0] RESULT_RESET    = 32'h00000000;
    localparam int          BITS_PER_BYTE   = 8;
endpackage

// ===== core/crc_unit.sv
`timescale 1ns/100ps
module crc_unit
    import crc_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RSTN,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       RES_RD,
    input  wire logic       RES_WR,
    input  wire logic [7:0] RES_WDATA,
    output logic      [7:0] RES_RDATA
);
    // =====================================================
    // state
    logic        sel16_q;
    logic        val_q;
    logic [1:0]  pnt_q;
    logic [1:0]  pnt_d;
    logic [7:0]  din_q;
    logic [31:0] result_q;
    logic [31:0] result_d;
    logic [7:0]  sfr_rdata_d;
    logic [7:0]  res_rdata_d;

    // =====================================================
    // decoded strobes and derived words
    logic        ctrl_wr;
    logic        din_wr;
    logic        res_access;
    logic        init_hit;
    logic [1:0]  lane;
    logic [31:0] seed_word;
    logic [31:0] merged_word;

    crc_fold_if fold ();

    // =====================================================
    // helpers
    // a strobe aimed at one register address
    function automatic logic hits(input logic       strobe,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
        return strobe && (addr == target);
    endfunction

    // 16-bit mode folds the pointer onto the low two lanes
    function automatic logic [1:0] lane_of(input logic [1:0] p,
                                           input logic       narrow);
        return narrow ? {1'b0, p[0]} : p;
    endfunction

    function automatic logic [31:0] seed_of(input logic ones);
        return ones ? SEED_ONES : SEED_ZERO;
    endfunction

    // one lane of a result word
    function automatic logic [7:0] byte_of(input logic [31:0] word,
                                           input logic [1:0]  l);
        return word[l*BITS_PER_BYTE +: BITS_PER_BYTE];
    endfunction

    // result word with one lane replaced by a port write
    function automatic logic [31:0] put_byte(input logic [31:0] word,
                                             input logic [1:0]  l,
                                             input logic [7:0]  b);
        logic [31:0] w;
        w = word;
        w[l*BITS_PER_BYTE +: BITS_PER_BYTE] = b;
        return w;
    endfunction

    // init strobe has no storage, so it reads back as zero
    function automatic logic [7:0] ctrl_image(input logic       sel16,
                                              input logic       val,
                                              input logic [1:0] pnt);
        logic [7:0] img;
        img               = 8'h00;
        img[SEL_BIT]      = sel16;
        img[VAL_BIT]      = val;
        img[PNT_LSB +: 2] = pnt;
        return img;
    endfunction

    // =====================================================
    // decode
    assign ctrl_wr     = hits(SFR_WR, SFR_ADDR, CTRL_ADDR);
    assign din_wr      = hits(SFR_WR, SFR_ADDR, DIN_ADDR);
    assign res_access  = RES_RD || RES_WR;
    assign init_hit    = ctrl_wr && SFR_WDATA[INIT_BIT];
    assign lane        = lane_of(pnt_q, sel16_q);
    assign seed_word   = seed_of(SFR_WDATA[VAL_BIT]);
    assign merged_word = put_byte(result_q, lane, RES_WDATA);

    // the whole byte folds in one cycle, eight xor levels deep,
    // so software never has to poll a busy flag
    assign fold.acc    = result_q;
    assign fold.din    = SFR_WDATA;
    assign fold.narrow = sel16_q;

    crc_byte_fold crc_byte_fold_inst (
        .fold (fold)
    );

    // =====================================================
    // control register, one flop each for the select and seed-value fields
    // bits 7:5 have no flop, so writes to them are lost
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sel16_q <= CTRL_RESET[SEL_BIT];
        end else if (ctrl_wr) begin
            sel16_q <= SFR_WDATA[SEL_BIT];
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            val_q <= CTRL_RESET[VAL_BIT];
        end else if (ctrl_wr) begin
            val_q <= SFR_WDATA[VAL_BIT];
        end
    end

    // =====================================================
    // result byte pointer
    // software write of the pointer beats a same-cycle increment
    always_comb begin
        pnt_d = pnt_q;
        if (ctrl_wr) begin
            pnt_d = SFR_WDATA[PNT_LSB +: 2];
        end else if (res_access) begin
            pnt_d = pnt_q + 2'h1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pnt_q <= CTRL_RESET[PNT_LSB +: 2];
        end else begin
            pnt_q <= pnt_d;
        end
    end

    // =====================================================
    // data input register, kept only for read-back
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            din_q <= DIN_RESET;
        end else if (din_wr) begin
            din_q <= SFR_WDATA;
        end
    end

    // =====================================================
    // result register; init uses the seed select written with it
    // init beats a port write, which beats a fold
    // a fold lost to a same-cycle port write is not retried
    always_comb begin
        result_d = result_q;
        if (init_hit) begin
            result_d = seed_word;
        end else if (RES_WR) begin
            result_d = merged_word;
        end else if (din_wr) begin
            result_d = fold.next;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            result_q <= RESULT_RESET;
        end else begin
            result_q <= result_d;
        end
    end

    // =====================================================
    // read data, registered one cycle after the strobe
    // unmapped addresses read as zero
    always_comb begin
        sfr_rdata_d = 8'h00;
        unique case (SFR_ADDR)
            CTRL_ADDR: sfr_rdata_d = ctrl_image(sel16_q, val_q,
                                                pnt_q);
            DIN_ADDR:  sfr_rdata_d = din_q;
            default:   sfr_rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            SFR_RDATA <= 8'h00;
        end else if (SFR_RD) begin
            SFR_RDATA <= sfr_rdata_d;
        end
    end

    // the port byte is sampled before any same-cycle write lands
    assign res_rdata_d = byte_of(result_q, lane);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RES_RDATA <= 8'h00;
        end else if (RES_RD) begin
            RES_RDATA <= res_rdata_d;
        end
    end
endmodule
